/* srbw_pkg.sv */
package srbw_pkg;
  localparam int CNT_W = 16;
  localparam int SET_W = 8;
  localparam int CLK_PERIOD_NS = 8;
  // ------------------------------------------------------------
  // timing, ns as given, cycles derived (least: round up)
  // ------------------------------------------------------------
  localparam int TON_FLOOR_NS = 55;
  localparam int TOFF_FLOOR_NS = 70;
  localparam int NEEDLE_MAX_NS = 100;
  localparam int FIXED_TON_NS = 200;
  localparam int FIXED_TOFF_NS = 1000;
  localparam int SET_STEP_NS = 16;
  localparam int RECOVERY_NS = 8000;
  localparam int DIS_ENTRY_NS = 20000;
  localparam int DIS_END_NS = 4000;
  localparam logic [CNT_W-1:0] TON_FLOOR_CYC =
    CNT_W'((TON_FLOOR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] TOFF_FLOOR_CYC =
    CNT_W'((TOFF_FLOOR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int NEEDLE_MAX_CYC = NEEDLE_MAX_NS / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] FIXED_TON_CYC =
    CNT_W'((FIXED_TON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] FIXED_TOFF_CYC =
    CNT_W'((FIXED_TOFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] SET_STEP_CYC =
    CNT_W'((SET_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // recovery is an upper bound: round down
  localparam logic [CNT_W-1:0] RECOVERY_CYC = CNT_W'(RECOVERY_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] DIS_ENTRY_CYC =
    CNT_W'((DIS_ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] DIS_END_CYC =
    CNT_W'((DIS_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
  localparam logic [1:0] STRAP_CAPTURE = 2'h3;
  // ------------------------------------------------------------
  // synchroniser lanes
  // ------------------------------------------------------------
  localparam int SI_TRIG = 0;
  localparam int SI_REARM = 1;
  localparam int SI_ONCMP = 2;
  localparam int SI_OFFCMP = 3;
  localparam int SI_NEG = 4;
  localparam int SI_ADJ = 5;
  localparam int SI_TON = 6;
  localparam int SI_TOFF = SI_TON + SET_W;
  localparam int SYNC_W = SI_TOFF + SET_W;
  typedef enum logic [2:0] {
    ST_RECOVER = 3'h0,
    ST_WAKE = 3'h1,
    ST_ARMED = 3'h3,
    ST_ON = 3'h2,
    ST_OFF_WAIT = 3'h6,
    ST_OFF_BLANK = 3'h7,
    ST_DISABLED = 3'h5
  } srbw_state_t;
endpackage

/* srbw_top.sv */
`timescale 1ns/1ps
module srbw_top (
  input wire logic CLOCK_IN, // 125 MHz
  input wire logic RESET_IN, // async, active high
  input wire logic TRIGGER_DISABLE_INPUT_IN, // trigger_disable_input pin
  input wire logic CS_ABOVE_REARM_IN, // drain above rearm_threshold
  input wire logic CS_BELOW_ON_IN, // drain below turn_on_threshold
  input wire logic CS_ABOVE_OFF_IN, // turn-off comparator
  input wire logic CS_NEGATIVE_IN, // drain below zero
  input wire logic LIGHT_LOAD_WAKE_IN, // light_load_detect wake pulse, same clock
  input wire logic ADJUST_SEL_IN, // strap: 1 adjustable, 0 fixed
  input wire logic [srbw_pkg::SET_W-1:0] TON_SETTING_IN, // min on-time setting
  input wire logic [srbw_pkg::SET_W-1:0] TOFF_SETTING_IN, // min off-time setting
  output logic GATE_DRIVE_OUT, // gate_drive_output request
  output logic DISABLED_OUT, // in disable mode
  output logic NORMAL_OUT // normal switching mode
);
  import srbw_pkg::*;

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic [SYNC_W-1:0] s1_q, s2_q;
  logic [1:0] prev_q; // [0] trig, [1] rearm, taken from s2 only
  always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      s1_q <= '0;
      s2_q <= '0;
      prev_q <= 2'h0;
    end else begin
      // settings are quasi-static; a moving setting may be off by one step for a cycle
      s1_q <= {TOFF_SETTING_IN, TON_SETTING_IN, ADJUST_SEL_IN, CS_NEGATIVE_IN,
               CS_ABOVE_OFF_IN, CS_BELOW_ON_IN, CS_ABOVE_REARM_IN, TRIGGER_DISABLE_INPUT_IN};
      s2_q <= s1_q;
      prev_q <= {s2_q[SI_REARM], s2_q[SI_TRIG]};
    end
  end
  logic trig, rearm_hi, on_cmp, off_cmp, neg, trig_rise, trig_edge, rearm_edge;
  assign trig = s2_q[SI_TRIG];
  assign rearm_hi = s2_q[SI_REARM];
  assign on_cmp = s2_q[SI_ONCMP];
  assign off_cmp = s2_q[SI_OFFCMP];
  assign neg = s2_q[SI_NEG];
  assign trig_rise = trig & ~prev_q[0];
  assign trig_edge = trig ^ prev_q[0];
  assign rearm_edge = rearm_hi ^ prev_q[1];

  // ------------------------------------------------------------
  // variant strap and blanking lengths
  // ------------------------------------------------------------
  logic [1:0] strap_cnt_q;
  logic adjust_q;
  always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      strap_cnt_q <= 2'h0;
      adjust_q <= 1'b0;
    end else if (strap_cnt_q != STRAP_CAPTURE) begin
      // caught once, after the synchroniser has filled; frozen until next reset
      strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_cnt_q + 2'h1 == STRAP_CAPTURE) begin
        adjust_q <= s2_q[SI_ADJ];
      end
    end
  end
  logic [CNT_W-1:0] ton_len, toff_len;
  always_comb begin
    logic [CNT_W-1:0] ton_raw;
    logic [CNT_W-1:0] toff_raw;
    ton_raw = CNT_W'(s2_q[SI_TON +: SET_W]) * SET_STEP_CYC;
    toff_raw = CNT_W'(s2_q[SI_TOFF +: SET_W]) * SET_STEP_CYC;
    if (!adjust_q) begin
      ton_raw = FIXED_TON_CYC;
      toff_raw = FIXED_TOFF_CYC;
    end
    ton_len = (ton_raw < TON_FLOOR_CYC) ? TON_FLOOR_CYC : ton_raw;
    toff_len = (toff_raw < TOFF_FLOOR_CYC) ? TOFF_FLOOR_CYC : toff_raw;
  end

  // ------------------------------------------------------------
  // trigger level duration
  // ------------------------------------------------------------
  logic [CNT_W-1:0] trig_cnt_q;
  always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      trig_cnt_q <= '0;
    end else if (trig_edge) begin
      trig_cnt_q <= '0;
    end else if (trig_cnt_q != CNT_MAX) begin
      trig_cnt_q <= trig_cnt_q + 16'h0001;
    end
  end
  logic dis_enter, dis_exit;
  // on the edge cycle the count still holds the length of the previous level
  assign dis_enter = trig & ~trig_edge & (trig_cnt_q >= DIS_ENTRY_CYC);
  assign dis_exit = ~trig & ~trig_edge & (trig_cnt_q >= DIS_END_CYC - 16'h0001);

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  srbw_state_t state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d, cnt_inc;
  assign cnt_inc = (cnt_q == CNT_MAX) ? cnt_q : cnt_q + 16'h0001;
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_inc;
    unique case (state_q)
      ST_DISABLED: begin
        if (dis_exit) begin
          state_d = ST_RECOVER;
          cnt_d = '0;
        end
      end
      ST_RECOVER: begin
        // trigger going high again does not interrupt this count
        if (cnt_q >= RECOVERY_CYC - 16'h0001) begin
          state_d = ST_WAKE;
          cnt_d = '0;
        end
      end
      ST_WAKE: begin
        if (!rearm_hi || neg || rearm_edge) begin
          cnt_d = '0;
        end else if (cnt_q >= toff_len - 16'h0001) begin
          state_d = ST_ARMED;
          cnt_d = '0;
        end
      end
      ST_ARMED: begin
        // a high trigger level also blocks turn-on
        if (on_cmp && !trig) begin
          state_d = ST_ON;
          cnt_d = '0;
        end
      end
      ST_ON: begin
        if (trig_rise) begin
          state_d = ST_OFF_WAIT;
        end else if (cnt_q >= ton_len - 16'h0001 && off_cmp) begin
          state_d = ST_OFF_WAIT;
        end
      end
      ST_OFF_WAIT: begin
        if (rearm_hi) begin
          state_d = ST_OFF_BLANK;
          cnt_d = '0;
        end
      end
      ST_OFF_BLANK: begin
        if (rearm_edge) begin
          cnt_d = '0;
        end else if (cnt_q >= toff_len - 16'h0001) begin
          state_d = ST_ARMED;
          cnt_d = '0;
        end
      end
      default: begin
        state_d = ST_WAKE;
        cnt_d = '0;
      end
    endcase
    if (dis_enter && state_q != ST_DISABLED && state_q != ST_RECOVER) begin
      state_d = ST_DISABLED;
      cnt_d = '0;
    end
    if (LIGHT_LOAD_WAKE_IN) begin
      // light-load wake recovers exactly like a trigger exit
      state_d = ST_RECOVER;
      cnt_d = '0;
    end
  end
  always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      state_q <= ST_WAKE;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      GATE_DRIVE_OUT <= 1'b0;
      DISABLED_OUT <= 1'b0;
      NORMAL_OUT <= 1'b0;
    end else begin
      GATE_DRIVE_OUT <= (state_d == ST_ON);
      DISABLED_OUT <= (state_d == ST_DISABLED);
      NORMAL_OUT <= (state_d == ST_ARMED) || (state_d == ST_ON) ||
                    (state_d == ST_OFF_WAIT) || (state_d == ST_OFF_BLANK);
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (RESET_IN);
  logic quiet;
  assign quiet = !LIGHT_LOAD_WAKE_IN && !dis_enter;

  recovery_length_a: assert property (
    state_q == ST_WAKE && $past(state_q) == ST_RECOVER |-> $past(cnt_q) == RECOVERY_CYC - 16'h0001)
    else $error("recovery left early");
  gate_low_recover_a: assert property (
    state_q == ST_RECOVER || state_q == ST_DISABLED |-> !GATE_DRIVE_OUT)
    else $error("gate high during disable or recovery");
  wake_gate_low_a: assert property (
    state_q == ST_WAKE |-> !GATE_DRIVE_OUT && !NORMAL_OUT)
    else $error("gate before full off-time");
  full_toff_armed_a: assert property (
    state_q == ST_ARMED && $past(state_q) == ST_WAKE |-> $past(cnt_q) == $past(toff_len) - 16'h0001)
    else $error("normal mode without full off-time");
  neg_abandon_a: assert property (
    state_q == ST_WAKE && neg && quiet |=> state_q == ST_WAKE && cnt_q == '0)
    else $error("negative drain did not abandon run");
  wake_run_a: assert property (
    state_q == ST_WAKE && rearm_hi && !neg && !rearm_edge && quiet
      && cnt_q < toff_len - 16'h0001 |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("off-time not running above rearm");
  ringing_restart_a: assert property (
    state_q == ST_OFF_BLANK && rearm_edge && quiet |=> state_q == ST_OFF_BLANK && cnt_q == '0)
    else $error("rearm crossing did not restart blanking");
  ton_blank_a: assert property (
    state_q == ST_ON && cnt_q < ton_len - 16'h0001 && !trig_rise && quiet |=> GATE_DRIVE_OUT)
    else $error("turn-off during on-time blanking");
  toff_blank_a: assert property (
    state_q == ST_OFF_BLANK || state_q == ST_OFF_WAIT |=> !GATE_DRIVE_OUT)
    else $error("turn-on during off-time blanking");
  trig_edge_off_a: assert property (
    state_q == ST_ON && trig_rise |=> !GATE_DRIVE_OUT)
    else $error("trigger edge did not turn off");
  disable_entry_a: assert property (
    dis_enter && state_q != ST_RECOVER && !LIGHT_LOAD_WAKE_IN |=> DISABLED_OUT && !GATE_DRIVE_OUT)
    else $error("disable entry missed");
  floor_a: assert property (
    ton_len >= TON_FLOOR_CYC && toff_len >= TOFF_FLOOR_CYC)
    else $error("blanking below floor");
  fixed_a: assert property (
    strap_cnt_q == STRAP_CAPTURE && !adjust_q |-> ton_len == FIXED_TON_CYC
      && toff_len == FIXED_TOFF_CYC)
    else $error("fixed variant timing altered");

  wake_to_armed_c: cover property (state_q == ST_WAKE ##1 state_q == ST_ARMED);
  needle_off_c: cover property (state_q == ST_ON && trig_rise ##1 !trig ##1 !GATE_DRIVE_OUT);
  recover_c: cover property (state_q == ST_DISABLED ##1 state_q == ST_RECOVER);
  switching_c: cover property (state_q == ST_OFF_BLANK ##1 state_q == ST_ARMED ##[1:50] GATE_DRIVE_OUT);
endmodule

/* srbw_drain_model.sv */
`timescale 1ns/1ps
module srbw_drain_model (
  input wire logic [1:0] level_in, // 0 negative, 1 near zero, 2 high
  output logic above_rearm_out, // drain above rearm level
  output logic below_on_out, // drain below turn-on level
  output logic above_off_out, // turn-off comparator
  output logic negative_out // drain below zero
);
  // ----------------------------------------
  // comparator bank
  // ----------------------------------------
  // thresholds ordered neg < on < off < rearm, so the flags never contradict each other
  always_comb begin
    above_rearm_out = (level_in == 2'h2);
    below_on_out = (level_in == 2'h0);
    above_off_out = (level_in != 2'h0);
    negative_out = (level_in == 2'h0);
  end
endmodule

/* srbw_top_tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
  $display("[ERR] t=%0t got %0h exp %0h", $time, (a), (b)); end end
module srbw_top_tb_top;
  import srbw_pkg::*;
  localparam logic [1:0] NEG = 2'h0;
  localparam logic [1:0] ZERO = 2'h1;
  localparam logic [1:0] HIGH = 2'h2;
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  logic trig = 1'b0;
  logic llw = 1'b0;
  logic adj = 1'b0;
  logic [SET_W-1:0] ton_set = 8'h00;
  logic [SET_W-1:0] toff_set = 8'h00;
  logic [1:0] level = 2'h2;
  logic rearm, below_on, above_off, negative, gate, disabled, normal;
  int err_count = 0;
  int compares = 0;
  int n;
  srbw_drain_model i_srbw_drain_model (.level_in(level), .above_rearm_out(rearm),
    .below_on_out(below_on), .above_off_out(above_off), .negative_out(negative));
  srbw_top i_srbw_top (.CLOCK_IN(clock_in), .RESET_IN(reset_in), .TRIGGER_DISABLE_INPUT_IN(trig),
    .CS_ABOVE_REARM_IN(rearm), .CS_BELOW_ON_IN(below_on), .CS_ABOVE_OFF_IN(above_off),
    .CS_NEGATIVE_IN(negative), .LIGHT_LOAD_WAKE_IN(llw), .ADJUST_SEL_IN(adj),
    .TON_SETTING_IN(ton_set), .TOFF_SETTING_IN(toff_set), .GATE_DRIVE_OUT(gate),
    .DISABLED_OUT(disabled), .NORMAL_OUT(normal));
  initial forever #4 clock_in = ~clock_in;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic step(input int k);
    repeat (k) @(negedge clock_in);
  endtask
  task automatic do_reset(input logic a, input logic [SET_W-1:0] t_on, t_off);
    reset_in = 1'b1;
    adj = a;
    ton_set = t_on;
    toff_set = t_off;
    level = HIGH;
    trig = 1'b0;
    step(12);
    reset_in = 1'b0;
  endtask
  // counts cycles until normal mode, the gate must stay off all the while
  task automatic wait_normal(output int k);
    k = 0;
    while (normal !== 1'b1 && k < 6000) begin
      `CHK(gate, 1'b0)
      step(1);
      k++;
    end
  endtask
  task automatic measure_on(input int exp_on);
    int k;
    level = NEG;
    step(2);
    `CHK(gate, 1'b0)
    step(1);
    `CHK(gate, 1'b1)
    level = ZERO;
    k = 1;
    while (gate === 1'b1 && k < 600) begin
      step(1);
      if (gate === 1'b1) k++;
    end
    `CHK(k >= exp_on && k <= exp_on + 2, 1'b1)
    level = HIGH;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_startup_fixed();
    do_reset(1'b0, 8'h03, 8'h03);
    wait_normal(n);
    `CHK(n >= FIXED_TOFF_CYC && n <= FIXED_TOFF_CYC + 5, 1'b1)
    measure_on(FIXED_TON_CYC);
    step(FIXED_TOFF_CYC - 10);
    level = NEG;
    step(6);
    `CHK(gate, 1'b0)
    level = HIGH;
    step(FIXED_TOFF_CYC + 5);
    measure_on(FIXED_TON_CYC);
  endtask
  task automatic t_ringing();
    do_reset(1'b0, 8'h00, 8'h00);
    repeat (4) begin
      step(FIXED_TOFF_CYC - 20);
      level = ZERO;
      step(3);
      `CHK(normal, 1'b0)
      level = HIGH;
    end
    wait_normal(n);
    `CHK(n >= FIXED_TOFF_CYC && n <= FIXED_TOFF_CYC + 5, 1'b1)
  endtask
  task automatic t_negative();
    do_reset(1'b0, 8'h00, 8'h00);
    step(60);
    level = NEG;
    step(10);
    `CHK(gate, 1'b0)
    level = HIGH;
    wait_normal(n);
    `CHK(n >= FIXED_TOFF_CYC && n <= FIXED_TOFF_CYC + 5, 1'b1)
  endtask
  task automatic t_needle();
    do_reset(1'b0, 8'h00, 8'h00);
    wait_normal(n);
    level = NEG;
    step(4);
    trig = 1'b1;
    step(1);
    trig = 1'b0;
    step(1);
    `CHK(gate, 1'b1)
    step(1);
    `CHK(gate, 1'b0)
    level = HIGH;
  endtask
  task automatic t_disable();
    do_reset(1'b0, 8'h00, 8'h00);
    wait_normal(n);
    trig = 1'b1;
    n = 0;
    while (disabled !== 1'b1 && n < 4000) begin
      `CHK(gate, 1'b0)
      step(1);
      n++;
    end
    `CHK(n >= DIS_ENTRY_CYC && n <= DIS_ENTRY_CYC + 5, 1'b1)
    trig = 1'b0;
    step(DIS_END_CYC - 5);
    `CHK(disabled, 1'b1)
    step(10);
    `CHK(disabled, 1'b0)
    trig = 1'b1;
    step(50);
    trig = 1'b0;
    wait_normal(n);
    `CHK(n >= RECOVERY_CYC - 60 + FIXED_TOFF_CYC, 1'b1)
    `CHK(n <= RECOVERY_CYC + FIXED_TOFF_CYC, 1'b1)
    llw = 1'b1;
    step(1);
    llw = 1'b0;
    step(3);
    `CHK(normal, 1'b0)
    wait_normal(n);
    `CHK(n >= RECOVERY_CYC + FIXED_TOFF_CYC - 8, 1'b1)
    `CHK(n <= RECOVERY_CYC + FIXED_TOFF_CYC + 8, 1'b1)
  endtask
  task automatic t_adjust();
    do_reset(1'b1, 8'h00, 8'h00);
    wait_normal(n);
    `CHK(n >= TOFF_FLOOR_CYC && n <= TOFF_FLOOR_CYC + 5, 1'b1)
    measure_on(TON_FLOOR_CYC);
    do_reset(1'b1, 8'h14, 8'h1E);
    wait_normal(n);
    `CHK(n >= 30 * SET_STEP_CYC && n <= 30 * SET_STEP_CYC + 5, 1'b1)
    measure_on(20 * SET_STEP_CYC);
  endtask
  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic finish_test();
    if (err_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    t_startup_fixed();
    t_ringing();
    t_negative();
    t_needle();
    t_disable();
    t_adjust();
    finish_test();
  end
  // the whole run needs about 7000 cycles, so this leaves ample margin
  initial begin
    repeat (40000) @(posedge clock_in);
    err_count++;
    finish_test();
  end
endmodule
